//--- hdl/peco_integ.sv
// data-integrity crc walker over an inclusive word range
// assumes: rd_data is the array word at rd_addr in the same cycle
`timescale 1ns/1ps
module peco_integ (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    start,
  input  wire logic [peco_pkg::AW-1:0] start_addr,
  input  wire logic [peco_pkg::AW-1:0] end_addr,
  input  wire logic                    suspend,
  output logic      [peco_pkg::AW-1:0] rd_addr,
  input  wire logic [peco_pkg::DW-1:0] rd_data,
  output logic                         busy,
  output logic      [31:0]             crc
);
  import peco_pkg::*;
  logic          run_ff;
  logic [AW-1:0] cur_ff;
  logic [31:0]   crc_ff;
  logic          nxt_run;
  logic [AW-1:0] nxt_cur;
  logic [31:0]   nxt_crc;

  always_comb begin
    nxt_run = run_ff;
    nxt_cur = cur_ff;
    nxt_crc = crc_ff;
    if (start) begin
      nxt_run = 1'b1;
      nxt_cur = start_addr;
      nxt_crc = CRC_INIT;
    end else if (run_ff && !suspend) begin
      nxt_crc = peco_crc(crc_ff, rd_data);
      if (cur_ff == end_addr) begin
        nxt_run = 1'b0;
      end else begin
        nxt_cur = cur_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run_ff <= 1'b0;
      cur_ff <= '0;
      crc_ff <= CRC_INIT;
    end else begin
      run_ff <= nxt_run;
      cur_ff <= nxt_cur;
      crc_ff <= nxt_crc;
    end
  end

  assign rd_addr = cur_ff;
  assign busy    = run_ff;
  assign crc     = crc_ff;
endmodule

//--- hdl/peco_pkg.sv
// package: constants, types and crc step for the overlay command block
// assumes: word-wide bus cycles, 16 sectors of 4K words, 32-bit crc
package peco_pkg;
  localparam int          AW          = 16;
  localparam int          DW          = 16;
  localparam int          NSEC        = 16;
  localparam int          SEC_LSB     = 12;
  localparam int          HP_LSB      = 3;
  localparam logic [11:0] UNLK1_ADDR  = 12'h555;
  localparam logic [11:0] UNLK2_ADDR  = 12'h2AA;
  localparam logic [7:0]  UNLK1_DATA  = 8'hAA;
  localparam logic [7:0]  UNLK2_DATA  = 8'h55;
  // entry codes, third cycle after the unlock pair
  localparam logic [7:0]  ENT_PERS    = 8'hC0;
  localparam logic [7:0]  ENT_LOCK    = 8'h50;
  localparam logic [7:0]  ENT_DYN     = 8'hE0;
  localparam logic [7:0]  ENT_CORR    = 8'h75;
  localparam logic [7:0]  ENT_LCRC    = 8'h78;
  localparam logic [7:0]  ENT_INTEG   = 8'h7C;
  localparam logic [7:0]  ENT_BOOT    = 8'h7E;
  // codes inside an overlay
  localparam logic [7:0]  OP_EXIT     = 8'h90;
  localparam logic [7:0]  OP_PGM      = 8'hA0;
  localparam logic [7:0]  OP_ERASE    = 8'h80;
  localparam logic [7:0]  OP_ABRST    = 8'hF0;
  localparam logic [7:0]  OP_STATUS   = 8'h60;
  localparam logic [7:0]  OP_CLR      = 8'h30;
  localparam logic [7:0]  OP_SET      = 8'h31;
  localparam logic [7:0]  OP_LO       = 8'h41;
  localparam logic [7:0]  OP_HI       = 8'h42;
  localparam logic [7:0]  OP_COUNT    = 8'h43;
  localparam logic [7:0]  OP_START    = 8'h10;
  localparam logic [7:0]  OP_END      = 8'h11;
  localparam logic [7:0]  OP_SUSP     = 8'h12;
  localparam logic [7:0]  OP_RES      = 8'h13;
  // reset values
  localparam logic [NSEC-1:0] GUARD_RST = 16'hFFFF;
  localparam logic            LOCK_RST  = 1'b1;
  localparam logic [31:0]     BOOT_RST  = 32'h0000_0000;
  localparam logic [31:0]     CRC_INIT  = 32'hFFFF_FFFF;
  localparam logic [31:0]     CRC_POLY  = 32'h04C1_1DB7;
  localparam logic [12:0]     STAT_PAD  = 13'h1FFF;
  // select idle high, every other pin low
  localparam logic [AW+DW+2:0] SYNC_RST = 35'h4_0000_0000;

  typedef enum logic [2:0] {
    MD_ARRAY, MD_PERS, MD_LOCK, MD_DYN, MD_CORR, MD_LCRC, MD_INTEG, MD_BOOT
  } peco_mode_t;

  typedef enum logic [3:0] {
    PN_NONE, PN_PGM, PN_ERASE, PN_STATUS, PN_LCLR, PN_DSET, PN_DCLR,
    PN_TLO, PN_THI, PN_CNT, PN_ILO, PN_IHI, PN_BPGM
  } peco_pend_t;

  function automatic logic [31:0] peco_crc(input logic [31:0] c,
                                           input logic [15:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 15; i >= 0; i--) begin
      r = (r[31] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction
endpackage

//--- hdl/peco_sync.sv
// three-stage synchroniser for a vector of pins
// assumes: the whole vector is held steady around each link clock edge
`timescale 1ns/1ps
module peco_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] RSTV = '0
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] q_ff;
  logic [W-1:0] nxt_q;

  // change taken once second and third stages agree
  always_comb begin
    nxt_q = (s2_ff == s3_ff) ? s3_ff : q_ff;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= RSTV;
      s2_ff <= RSTV;
      s3_ff <= RSTV;
      q_ff  <= RSTV;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff  <= nxt_q;
    end
  end

  assign q = q_ff;
endmodule

//--- hdl/peco_top.sv
// overlay command interpreter: protection, correction, crc, boot config
// assumes: link pins from a host on its own clock, array read same cycle
// Summary of operation
// - three-cycle entry opens persistent overlay; its bit in bit 0 everywhere.
// - two-cycle program clears the addressed sector's persistent bit.
// - two-cycle erase sets every sector's persistent bit at once.
// - failed program sets abort flag; three-cycle reset clears it.
// - status read: bit0 overall, bit1 dynamic, bit2 persistent, rest ones.
// - three-cycle entry opens lock overlay; lock bit in bit 0 everywhere.
// - two-cycle clear drops lock bit; one-cycle read returns it.
// - two-cycle set raises addressed sector's dynamic bit.
// - two-cycle clear drops addressed sector's dynamic bit.
// - one-cycle read returns sector's dynamic bit in bit 0.
// - correction status read gives one word per half-page.
// - 32-bit trap address read as two 16-bit halves.
// - two-cycle read returns count of correction actions.
// - one-cycle clear resets failure flags and reported alert.
// - three-cycle entry opens link crc overlay; exit clears it.
// - link crc read: low half at 0x00, high half at 0x01.
// - running integrity crc hides array; suspended shows it.
// - start and end addresses loaded by one-cycle writes.
// - suspend and resume pause the walk; suspended reads give array.
// - integrity value read as low and high halves.
// - boot config two-cycle program; halves read at 0x00 and 0x01.
`timescale 1ns/1ps
module peco_top (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    bus_ck,
  input  wire logic                    bus_cs_n,
  input  wire logic                    bus_rd,
  input  wire logic [peco_pkg::AW-1:0] bus_addr,
  input  wire logic [peco_pkg::DW-1:0] dq_i,
  output logic      [peco_pkg::DW-1:0] dq_o,
  output logic                         dq_oe,
  output logic      [peco_pkg::AW-1:0] array_addr,
  input  wire logic [peco_pkg::DW-1:0] array_rdata,
  output logic      [peco_pkg::AW-1:0] integ_addr,
  input  wire logic [peco_pkg::DW-1:0] integ_rdata,
  input  wire logic                    ecc_corr,
  input  wire logic                    ecc_fail,
  input  wire logic [31:0]             ecc_addr,
  output logic                         abort_flag,
  output logic                         ecc_alert,
  output logic                         integ_busy,
  output logic      [31:0]             boot_cfg
);
  import peco_pkg::*;
  localparam int SW = AW + DW + 3;

  logic [SW-1:0]   pin_q;
  logic            ck_q;
  logic            cs_n_q;
  logic            ck_prev_ff;
  logic            cyc_ff;
  logic            crd_ff;
  logic [AW-1:0]   caddr_ff;
  logic [DW-1:0]   cdin_ff;
  logic            nxt_cyc;
  peco_mode_t      mode_ff, nxt_mode;
  peco_pend_t      pend_ff, nxt_pend;
  logic [1:0]      step_ff, nxt_step;
  logic [NSEC-1:0] pguard_ff, nxt_pguard;
  logic [NSEC-1:0] dguard_ff, nxt_dguard;
  logic            glock_ff, nxt_glock;
  logic            abort_ff, nxt_abort;
  logic            fail_ff, nxt_fail;
  logic [31:0]     trap_ff, nxt_trap;
  logic [15:0]     cnt_ff, nxt_cnt;
  logic [31:0]     lcrc_ff, nxt_lcrc;
  logic [31:0]     boot_ff, nxt_boot;
  logic [AW-1:0]   istart_ff, nxt_istart;
  logic [AW-1:0]   iend_ff, nxt_iend;
  logic            isusp_ff, nxt_isusp;
  logic            igo_ff, nxt_igo;
  logic [DW-1:0]   dout_ff, nxt_dout;
  logic            oe_ff, nxt_oe;
  logic            ibusy;
  logic [31:0]     icrc;
  logic            wr;
  logic            rd;
  logic [7:0]      code;
  logic [3:0]      sec;
  logic            hp_hit;
  logic            bare;

  peco_sync #(.W(SW), .RSTV(SYNC_RST)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .d       ({bus_cs_n, bus_ck, bus_rd, bus_addr, dq_i}),
    .q       (pin_q)
  );

  assign cs_n_q = pin_q[SW-1];
  assign ck_q   = pin_q[SW-2];

  peco_integ u_integ (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .start      (igo_ff),
    .start_addr (istart_ff),
    .end_addr   (iend_ff),
    .suspend    (isusp_ff),
    .rd_addr    (integ_addr),
    .rd_data    (integ_rdata),
    .busy       (ibusy),
    .crc        (icrc)
  );

  // one bus cycle per rising link clock edge while selected
  always_comb begin
    nxt_cyc = ck_q && !ck_prev_ff && !cs_n_q;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ck_prev_ff <= 1'b0;
      cyc_ff     <= 1'b0;
      crd_ff     <= 1'b0;
      caddr_ff   <= '0;
      cdin_ff    <= '0;
    end else begin
      ck_prev_ff <= ck_q;
      cyc_ff     <= nxt_cyc;
      crd_ff     <= pin_q[SW-3];
      caddr_ff   <= pin_q[AW+DW-1:DW];
      cdin_ff    <= pin_q[DW-1:0];
    end
  end

  assign wr     = cyc_ff && !crd_ff;
  assign rd     = cyc_ff && crd_ff;
  assign code   = cdin_ff[7:0];
  assign sec    = caddr_ff[AW-1:SEC_LSB];
  assign hp_hit = trap_ff[AW-1:HP_LSB] == caddr_ff[AW-1:HP_LSB];
  assign bare   = wr && pend_ff == PN_NONE && step_ff == 2'd0;

  always_comb begin
    nxt_mode   = mode_ff;
    nxt_pend   = pend_ff;
    nxt_step   = step_ff;
    nxt_pguard = pguard_ff;
    nxt_dguard = dguard_ff;
    nxt_glock  = glock_ff;
    nxt_abort  = abort_ff;
    nxt_fail   = fail_ff;
    nxt_trap   = trap_ff;
    nxt_cnt    = cnt_ff;
    nxt_lcrc   = lcrc_ff;
    nxt_boot   = boot_ff;
    nxt_istart = istart_ff;
    nxt_iend   = iend_ff;
    nxt_isusp  = isusp_ff;
    nxt_igo    = 1'b0;
    nxt_dout   = dout_ff;
    nxt_oe     = oe_ff && !cs_n_q;
    if (cyc_ff) begin
      nxt_oe   = rd;
      nxt_pend = PN_NONE;
      nxt_step = 2'd0;
      if (wr) begin
        nxt_lcrc = peco_crc(lcrc_ff, cdin_ff);
        if (caddr_ff[11:0] == UNLK1_ADDR && code == UNLK1_DATA) begin
          nxt_step = 2'd1;
        end else if (step_ff == 2'd1 && caddr_ff[11:0] == UNLK2_ADDR
                     && code == UNLK2_DATA) begin
          nxt_step = 2'd2;
        end
      end
      case (mode_ff)
        MD_ARRAY: begin
          if (rd) begin
            nxt_dout = array_rdata;
          end else if (step_ff == 2'd2 && caddr_ff[11:0] == UNLK1_ADDR) begin
            case (code)
              ENT_PERS:  nxt_mode = MD_PERS;
              ENT_LOCK:  nxt_mode = MD_LOCK;
              ENT_DYN:   nxt_mode = MD_DYN;
              ENT_CORR:  nxt_mode = MD_CORR;
              ENT_LCRC:  nxt_mode = MD_LCRC;
              ENT_INTEG: nxt_mode = MD_INTEG;
              ENT_BOOT:  nxt_mode = MD_BOOT;
              default:   nxt_mode = MD_ARRAY;
            endcase
          end
        end
        MD_PERS, MD_DYN: begin
          if (rd && pend_ff == PN_STATUS) begin
            nxt_dout = {STAT_PAD, pguard_ff[sec], dguard_ff[sec],
                        pguard_ff[sec] & dguard_ff[sec]};
          end else if (rd) begin
            nxt_dout = {15'h0000, (mode_ff == MD_PERS) ?
                        pguard_ff[sec] : dguard_ff[sec]};
          end else if (pend_ff == PN_PGM || pend_ff == PN_ERASE) begin
            if (!glock_ff) begin
              nxt_abort = 1'b1;
            end else if (pend_ff == PN_PGM) begin
              nxt_pguard[sec] = 1'b0;
            end else begin
              nxt_pguard = '0;
              nxt_pguard = ~nxt_pguard;
            end
          end else if (pend_ff == PN_DSET) begin
            nxt_dguard[sec] = 1'b1;
          end else if (pend_ff == PN_DCLR) begin
            nxt_dguard[sec] = 1'b0;
          end else if (step_ff == 2'd2 && code == OP_ABRST
                       && mode_ff == MD_PERS) begin
            nxt_abort = 1'b0;
          end else if (bare) begin
            case (code)
              OP_PGM:    nxt_pend = (mode_ff == MD_PERS) ? PN_PGM : PN_NONE;
              OP_ERASE:  nxt_pend = (mode_ff == MD_PERS) ? PN_ERASE : PN_NONE;
              OP_SET:    nxt_pend = (mode_ff == MD_DYN) ? PN_DSET : PN_NONE;
              OP_CLR:    nxt_pend = (mode_ff == MD_DYN) ? PN_DCLR : PN_NONE;
              OP_STATUS: nxt_pend = PN_STATUS;
              default:   nxt_pend = PN_NONE;
            endcase
          end
        end
        MD_LOCK: begin
          if (rd) begin
            nxt_dout = {15'h0000, glock_ff};
          end else if (pend_ff == PN_LCLR) begin
            nxt_glock = 1'b0;
          end else if (bare && code == OP_CLR) begin
            nxt_pend = PN_LCLR;
          end
        end
        MD_CORR: begin
          if (rd) begin
            case (pend_ff)
              PN_TLO:  nxt_dout = trap_ff[15:0];
              PN_THI:  nxt_dout = trap_ff[31:16];
              PN_CNT:  nxt_dout = cnt_ff;
              default: nxt_dout = {14'h0000, fail_ff & hp_hit,
                                   hp_hit};
            endcase
          end else if (bare) begin
            case (code)
              OP_LO:    nxt_pend = PN_TLO;
              OP_HI:    nxt_pend = PN_THI;
              OP_COUNT: nxt_pend = PN_CNT;
              OP_CLR:   nxt_fail = 1'b0;
              default:  nxt_pend = PN_NONE;
            endcase
          end
        end
        MD_LCRC: begin
          if (rd) begin
            nxt_dout = caddr_ff[0] ? lcrc_ff[31:16] : lcrc_ff[15:0];
          end
        end
        MD_INTEG: begin
          if (rd && isusp_ff && pend_ff == PN_NONE) begin
            nxt_dout = array_rdata;
          end else if (rd) begin
            case (pend_ff)
              PN_ILO:  nxt_dout = icrc[15:0];
              PN_IHI:  nxt_dout = icrc[31:16];
              default: nxt_dout = {15'h0000, ibusy};
            endcase
          end else if (bare) begin
            case (code)
              OP_START: nxt_istart = caddr_ff;
              OP_END: begin
                nxt_iend = caddr_ff;
                nxt_igo  = 1'b1;
              end
              OP_SUSP:  nxt_isusp = 1'b1;
              OP_RES:   nxt_isusp = 1'b0;
              OP_LO:    nxt_pend  = PN_ILO;
              OP_HI:    nxt_pend  = PN_IHI;
              default:  nxt_pend  = PN_NONE;
            endcase
          end
        end
        MD_BOOT: begin
          if (rd) begin
            nxt_dout = caddr_ff[0] ? boot_ff[31:16] : boot_ff[15:0];
          end else if (pend_ff == PN_BPGM) begin
            if (caddr_ff[0]) begin
              nxt_boot[31:16] = cdin_ff;
            end else begin
              nxt_boot[15:0] = cdin_ff;
            end
          end else if (bare && code == OP_PGM) begin
            nxt_pend = PN_BPGM;
          end
        end
        default: nxt_mode = MD_ARRAY;
      endcase
      if (mode_ff != MD_ARRAY && bare && code == OP_EXIT) begin
        nxt_mode = MD_ARRAY;
        nxt_pend = PN_NONE;
        if (mode_ff == MD_LCRC) begin
          nxt_lcrc = CRC_INIT;
        end
      end
    end
    // correction failures win over a clear in the same cycle
    if (ecc_corr) begin
      nxt_trap = ecc_addr;
      nxt_cnt  = (cnt_ff == 16'hFFFF) ? cnt_ff : cnt_ff + 16'h0001;
    end
    if (ecc_fail) begin
      nxt_fail = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mode_ff   <= MD_ARRAY;
      pend_ff   <= PN_NONE;
      step_ff   <= 2'd0;
      pguard_ff <= GUARD_RST;
      dguard_ff <= GUARD_RST;
      glock_ff  <= LOCK_RST;
      abort_ff  <= 1'b0;
      fail_ff   <= 1'b0;
      trap_ff   <= '0;
      cnt_ff    <= '0;
      lcrc_ff   <= CRC_INIT;
      boot_ff   <= BOOT_RST;
      istart_ff <= '0;
      iend_ff   <= '0;
      isusp_ff  <= 1'b0;
      igo_ff    <= 1'b0;
      dout_ff   <= '0;
      oe_ff     <= 1'b0;
    end else begin
      mode_ff   <= nxt_mode;
      pend_ff   <= nxt_pend;
      step_ff   <= nxt_step;
      pguard_ff <= nxt_pguard;
      dguard_ff <= nxt_dguard;
      glock_ff  <= nxt_glock;
      abort_ff  <= nxt_abort;
      fail_ff   <= nxt_fail;
      trap_ff   <= nxt_trap;
      cnt_ff    <= nxt_cnt;
      lcrc_ff   <= nxt_lcrc;
      boot_ff   <= nxt_boot;
      istart_ff <= nxt_istart;
      iend_ff   <= nxt_iend;
      isusp_ff  <= nxt_isusp;
      igo_ff    <= nxt_igo;
      dout_ff   <= nxt_dout;
      oe_ff     <= nxt_oe;
    end
  end

  assign dq_o       = dout_ff;
  assign dq_oe      = oe_ff;
  assign array_addr = caddr_ff;
  assign abort_flag = abort_ff;
  assign ecc_alert  = fail_ff;
  assign integ_busy = ibusy;
  assign boot_cfg   = boot_ff;

  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_erase_all;
    wr && mode_ff == MD_PERS && pend_ff == PN_ERASE && glock_ff
      |=> pguard_ff == GUARD_RST;
  endproperty
  a_erase_all: assert property (p_erase_all)
    else $error("erase did not set all sector bits");

  property p_abort;
    wr && mode_ff == MD_PERS && pend_ff == PN_PGM && !glock_ff
      |=> abort_ff ##1 abort_flag;
  endproperty
  a_abort: assert property (p_abort)
    else $error("failed program did not raise abort");

  property p_lock_clr;
    wr && mode_ff == MD_LOCK && pend_ff == PN_LCLR |=> !glock_ff;
  endproperty
  a_lock_clr: assert property (p_lock_clr)
    else $error("lock bit not cleared");

  property p_dset;
    wr && mode_ff == MD_DYN && pend_ff == PN_DSET
      |=> dguard_ff[$past(sec)];
  endproperty
  a_dset: assert property (p_dset)
    else $error("dynamic bit not set");

  property p_dclr;
    wr && mode_ff == MD_DYN && pend_ff == PN_DCLR
      |=> !dguard_ff[$past(sec)];
  endproperty
  a_dclr: assert property (p_dclr)
    else $error("dynamic bit not cleared");

  property p_status;
    rd && mode_ff == MD_PERS && pend_ff == PN_STATUS
      |=> dq_oe && dq_o[15:3] == STAT_PAD
          && dq_o[2] == $past(pguard_ff[sec]);
  endproperty
  a_status: assert property (p_status)
    else $error("bad protection status word");

  property p_lcrc_exit;
    bare && mode_ff == MD_LCRC && code == OP_EXIT
      |=> mode_ff == MD_ARRAY && lcrc_ff == CRC_INIT;
  endproperty
  a_lcrc_exit: assert property (p_lcrc_exit)
    else $error("link crc not cleared on exit");

  property p_ecc_clr;
    bare && mode_ff == MD_CORR && code == OP_CLR && !ecc_fail
      |=> !fail_ff && !ecc_alert;
  endproperty
  a_ecc_clr: assert property (p_ecc_clr)
    else $error("failure flag not cleared");

  property p_count;
    ecc_corr && cnt_ff != 16'hFFFF |=> cnt_ff == 16'($past(cnt_ff) + 1);
  endproperty
  a_count: assert property (p_count)
    else $error("correction count did not step");

  property p_stay;
    mode_ff != MD_ARRAY && !cyc_ff |=> mode_ff == $past(mode_ff);
  endproperty
  a_stay: assert property (p_stay)
    else $error("overlay left without a bus cycle");

  c_pers:  cover property (mode_ff == MD_PERS ##[1:200] mode_ff == MD_ARRAY);
  c_integ: cover property (igo_ff ##[1:400] !ibusy);
  c_boot:  cover property (wr && mode_ff == MD_BOOT && pend_ff == PN_BPGM);
endmodule

//--- sim/peco_host.sv
// host model: drives link cycles on the flash bus
// assumes: clk_sys at 25 MHz, link clock of 8 clk_sys per period
`timescale 1ns/1ps
module peco_host (
  input  wire logic        clk_sys,
  output logic             bus_ck,
  output logic             bus_cs_n,
  output logic             bus_rd,
  output logic      [15:0] bus_addr,
  output logic      [15:0] dq_i,
  input  wire logic [15:0] dq_o
);
  initial begin
    bus_ck   = 1'b0;
    bus_cs_n = 1'b1;
    bus_rd   = 1'b0;
    bus_addr = 16'h0000;
    dq_i     = 16'h0000;
  end
  // release the select between frames
  task automatic idle();
    bus_cs_n <= 1'b1;
  endtask
  // one cycle, held half a period each side of the rise
  task automatic cyc(input logic r, input logic [15:0] a, d,
                     output logic [15:0] q);
    bus_cs_n <= 1'b0;
    bus_rd   <= r;
    bus_addr <= a;
    dq_i     <= r ? ~dq_i : d;
    repeat (4) @(posedge clk_sys);
    bus_ck <= 1'b1;
    repeat (4) @(posedge clk_sys);
    bus_ck <= 1'b0;
    if (r) repeat (4) @(posedge clk_sys);
    q = dq_o;
  endtask
endmodule

//--- sim/test_peco_top.sv
// bench: random sector and data through every overlay
// assumes: array word is address xor a fixed pattern
`timescale 1ns/1ps
module test_peco_top;
  import peco_pkg::*;
  logic        clk_sys = 1'b0, rst_n = 1'b0, ecc_corr = 1'b0;
  logic        ecc_fail = 1'b0, bus_ck, bus_cs_n, bus_rd, dq_oe;
  logic        abort_flag, ecc_alert, integ_busy;
  logic [15:0] bus_addr, dq_i, dq_o, array_addr, integ_addr, sa, st;
  logic [31:0] ecc_addr = 32'h0, boot_cfg, crc, x, b;
  int          n_fail = 0, total_checks = 0, cyc_cnt = 0;
  wire  [15:0] array_rdata = array_addr ^ 16'h5A5A;
  wire  [15:0] integ_rdata = integ_addr ^ 16'hC3C3;
  peco_top peco_top_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .bus_ck(bus_ck), .bus_cs_n(bus_cs_n), .bus_rd(bus_rd),
    .bus_addr(bus_addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe),
    .array_addr(array_addr), .array_rdata(array_rdata),
    .integ_addr(integ_addr), .integ_rdata(integ_rdata),
    .ecc_corr(ecc_corr), .ecc_fail(ecc_fail), .ecc_addr(ecc_addr),
    .abort_flag(abort_flag), .ecc_alert(ecc_alert),
    .integ_busy(integ_busy), .boot_cfg(boot_cfg));
  peco_host peco_host_inst (.clk_sys(clk_sys), .bus_ck(bus_ck),
    .bus_cs_n(bus_cs_n), .bus_rd(bus_rd), .bus_addr(bus_addr),
    .dq_i(dq_i), .dq_o(dq_o));
  always #20 clk_sys = ~clk_sys;
  function automatic logic [31:0] f(input logic [31:0] c,
                                    input logic [15:0] d);
    for (int i = 15; i >= 0; i--) begin
      c = (c[31] ^ d[i]) ? (c << 1) ^ CRC_POLY : c << 1;
    end
    return c;
  endfunction
  task automatic stop_test();
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [15:0] a, d);
    logic [15:0] q;
    peco_host_inst.cyc(1'b0, a, d, q);
    crc = f(crc, d);
  endtask
  task automatic rd(input logic [15:0] a, e);
    logic [15:0] q;
    peco_host_inst.cyc(1'b1, a, 16'h0000, q);
    chk({31'h0, dq_oe}, 32'h1);
    chk({16'h0, q}, {16'h0, e});
  endtask
  task automatic op(input logic [7:0] c);
    wr(16'h0000, {8'h00, c});
  endtask
  task automatic ent(input logic [7:0] c);
    wr(16'h0555, 16'h00AA);
    wr(16'h02AA, 16'h0055);
    wr(16'h0555, {8'h00, c});
  endtask
  always @(posedge clk_sys) begin
    cyc_cnt++;
    if (cyc_cnt == 8000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(66458));
    crc = CRC_INIT;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    chk({dq_oe, abort_flag, ecc_alert, integ_busy}, 0);
    chk(boot_cfg, 0);
    repeat (5) @(posedge clk_sys);
    sa = $urandom;
    b = $urandom;
    st = $urandom;
    ent(ENT_LCRC);
    rd(16'h0000, crc[15:0]);
    rd(16'h0001, crc[31:16]);
    op(OP_EXIT);
    crc = CRC_INIT;
    ent(ENT_LCRC);
    rd(16'h0001, crc[31:16]);
    op(OP_EXIT);
    rd(sa, sa ^ 16'h5A5A);
    ent(ENT_PERS);
    rd(sa, 16'h0001);
    op(OP_PGM);
    wr(sa, 16'h0000);
    rd(sa ^ 16'h0FFF, 16'h0000);
    rd(sa ^ 16'h1000, 16'h0001);
    op(OP_STATUS);
    rd(sa, 16'hFFFA);
    op(OP_ERASE);
    wr(sa ^ 16'h2000, 16'h0000);
    rd(sa, 16'h0001);
    op(OP_EXIT);
    ent(ENT_DYN);
    op(OP_CLR);
    wr(sa, 16'h0000);
    rd(sa ^ 16'h0ABC, 16'h0000);
    rd(sa ^ 16'h1000, 16'h0001);
    op(OP_STATUS);
    rd(sa, 16'hFFFC);
    op(OP_SET);
    wr(sa, 16'h0000);
    rd(sa, 16'h0001);
    op(OP_EXIT);
    ent(ENT_LOCK);
    rd(sa, 16'h0001);
    op(OP_CLR);
    wr(sa, 16'h0000);
    rd(16'h0000, 16'h0000);
    op(OP_EXIT);
    ent(ENT_PERS);
    op(OP_PGM);
    wr(sa, 16'h0000);
    rd(sa, 16'h0001);
    chk({31'h0, abort_flag}, 1);
    ent(OP_ABRST);
    repeat (8) @(posedge clk_sys);
    chk({31'h0, abort_flag}, 0);
    op(OP_EXIT);
    ent(ENT_BOOT);
    op(OP_PGM);
    wr(16'h0000, b[15:0]);
    op(OP_PGM);
    wr(16'h0001, b[31:16]);
    rd(16'h0000, b[15:0]);
    rd(16'h0001, b[31:16]);
    chk(boot_cfg, b);
    op(OP_EXIT);
    ecc_addr <= {~sa, sa};
    ecc_corr <= 1'b1;
    ecc_fail <= 1'b1;
    @(posedge clk_sys);
    ecc_corr <= 1'b0;
    ecc_fail <= 1'b0;
    ent(ENT_CORR);
    op(OP_LO);
    rd(16'h0000, sa);
    op(OP_HI);
    rd(16'h0000, ~sa);
    op(OP_COUNT);
    rd(16'h0000, 16'h0001);
    rd(sa ^ 16'h0007, 16'h0003);
    chk({31'h0, ecc_alert}, 1);
    op(OP_CLR);
    rd(sa, 16'h0001);
    chk({31'h0, ecc_alert}, 0);
    op(OP_EXIT);
    ent(ENT_INTEG);
    wr(st, {8'h00, OP_START});
    wr(st + 16'h3, {8'h00, OP_END});
    x = CRC_INIT;
    for (int i = 0; i < 4; i++) x = f(x, (st + 16'(i)) ^ 16'hC3C3);
    repeat (20) @(posedge clk_sys);
    rd(sa, 16'h0000);
    op(OP_LO);
    rd(16'h0000, x[15:0]);
    op(OP_HI);
    rd(16'h0000, x[31:16]);
    op(OP_SUSP);
    rd(sa, sa ^ 16'h5A5A);
    op(OP_RES);
    rd(sa, 16'h0000);
    op(OP_EXIT);
    ent(ENT_DYN);
    repeat (4) @(posedge clk_sys);
    peco_host_inst.idle();
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk({dq_oe, abort_flag, ecc_alert, integ_busy}, 0);
    rd(sa, sa ^ 16'h5A5A);
    stop_test();
  end
endmodule
